/* File: inc/fppio_defs.vh */
// Overview of operation
// R1: output pins driven from latches; inputs unlatched
// R2: port read samples pins in S1
// R3: port write updates output in S2; here the latch updates in S2 and the pins one cycle later
// R4: reset: port0 latch ones, drive select zero
// R5: port0 per-bit open-drain or push-pull drive
// R6: port0 latch readable; separate pin-state register
// R7: software sets port0 latch before input use
// R8: port1 five bits, direction/latch reset zero
// R9: software sets latch before function output direction
// R10: port1 bit1 feeds interrupt even as output
// R11: port1 bit0 general or irq0, resets input
// R12: port2 three bits, latch resets to ones
// R13: dual-clock mode gives port2 bits 1,2 away
// R14: port2 bit0 falling edge feeds interrupt always
// R15: port2 reads define only bits 2 to 0
// R16: stop mode floats port2 bit0 output
// R17: reset: port3 direction, latch zero; disable set
// R18: disable zero makes selected port3 pins analog
// R19: port3 direction one drives latch bit
// R20: converter use: analog pins read latch, unwritable
// R21: software clears direction for key-on wakeup
// R22: read-modify-write reads pins for input bits
// R23: irq0 select: zero general, one interrupt
`ifndef FPPIO_DEFS_VH
`define FPPIO_DEFS_VH

// ============================================================
// register addresses
`define FPPIO_ADDR_P0_LATCH 6'h00
`define FPPIO_ADDR_P1_LATCH 6'h01
`define FPPIO_ADDR_P2_LATCH 6'h02
`define FPPIO_ADDR_P3_LATCH 6'h03
`define FPPIO_ADDR_P1_DIR 6'h09
`define FPPIO_ADDR_P3_DIR 6'h0A
`define FPPIO_ADDR_P0_DRIVE 6'h0B
`define FPPIO_ADDR_P0_PINS 6'h0C
`define FPPIO_ADDR_P2_PINS 6'h0D
`define FPPIO_ADDR_CONV_CTRL1 6'h0E
`define FPPIO_ADDR_EXT_IRQ_CTRL 6'h37

// ============================================================
// field positions
`define FPPIO_CONV_AIN_DIS_BIT 4
`define FPPIO_CONV_CHSEL_MSB 2
`define FPPIO_CONV_CHSEL_LSB 0
`define FPPIO_IRQ0_SEL_BIT 6
`define FPPIO_P2_DUAL_BIT_LO 1
`define FPPIO_P2_DUAL_BIT_HI 2

// ============================================================
// reset values
`define FPPIO_RST_P0_LATCH 8'hFF
`define FPPIO_RST_P0_DRIVE 8'h00
`define FPPIO_RST_P1_LATCH 5'h00
`define FPPIO_RST_P1_DIR 5'h00
`define FPPIO_RST_P2_LATCH 3'h7
`define FPPIO_RST_P3_LATCH 8'h00
`define FPPIO_RST_P3_DIR 8'h00
`define FPPIO_RST_CONV_CTRL1 8'h10
`define FPPIO_RST_EXT_IRQ_CTRL 8'h00

// ============================================================
// edge detector modes
`define FPPIO_EDGE_RISE 2'h0
`define FPPIO_EDGE_FALL 2'h1
`define FPPIO_EDGE_BOTH 2'h2

`endif

/* File: src/fppio_rst_sync.v */
`timescale 1ns/10ps
module fppio_rst_sync (
  input wire sys_clk_i,
  input wire rst_n_i,
  output wire rst_n_o
);
  reg meta_n_r;
  reg sync_n_r;

  // ============================================================
  // release through two flops, assert at once
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_n_r <= 1'b0;
      sync_n_r <= 1'b0;
    end else begin
      meta_n_r <= 1'b1;
      sync_n_r <= meta_n_r;
    end
  end

  assign rst_n_o = sync_n_r;
endmodule // fppio_rst_sync

/* File: src/fppio_edge_det.v */
`timescale 1ns/10ps
`include "fppio_defs.vh"
module fppio_edge_det #(
  parameter [1:0] MODE = `FPPIO_EDGE_BOTH
) (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire level_i,
  input wire enable_i,
  output reg pulse_o
);
  reg prev_r;
  reg armed_r;
  wire rise;
  wire fall;

  assign rise = level_i & ~prev_r;
  assign fall = ~level_i & prev_r;

  // ============================================================
  // edge pulse, one cycle after the change
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_r <= 1'b0;
      armed_r <= 1'b0;
      pulse_o <= 1'b0;
    end else begin
      prev_r <= level_i;
      // first sample only loads the level, so a high idle pin gives no false edge
      armed_r <= 1'b1;
      case (MODE)
        `FPPIO_EDGE_RISE: pulse_o <= armed_r & enable_i & rise;
        `FPPIO_EDGE_FALL: pulse_o <= armed_r & enable_i & fall;
        default: pulse_o <= armed_r & enable_i & (rise | fall);
      endcase
    end
  end
endmodule // fppio_edge_det

/* File: src/fppio_top.v */
`timescale 1ns/10ps
`include "fppio_defs.vh"
module fppio_top (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire [5:0] bus_addr_i,
  input wire [7:0] bus_wdata_i,
  input wire bus_rd_i,
  input wire bus_wr_i,
  output reg [7:0] bus_rdata_o,
  input wire stop_mode_i,
  input wire dual_clock_i,
  input wire [7:0] p0_pin_i,
  output reg [7:0] p0_out_o,
  output reg [7:0] p0_oe_o,
  input wire [4:0] p1_pin_i,
  output reg [4:0] p1_out_o,
  output reg [4:0] p1_oe_o,
  input wire [2:0] p2_pin_i,
  output reg [2:0] p2_out_o,
  output reg [2:0] p2_oe_o,
  output reg osc_pins_taken_o,
  input wire [7:0] p3_pin_i,
  output reg [7:0] p3_out_o,
  output reg [7:0] p3_oe_o,
  output reg [7:0] p3_analog_o,
  output reg [2:0] converter_channel_select_o,
  output reg irq0_edge_o,
  output reg irq_p11_edge_o,
  output reg irq_p20_edge_o
);
  reg [7:0] port0_output_latch_r;
  reg [7:0] port0_drive_select_r;
  reg [4:0] port1_output_latch_r;
  reg [4:0] port1_direction_r;
  reg [2:0] port2_output_latch_r;
  reg [7:0] port3_output_latch_r;
  reg [7:0] port3_direction_r;
  reg [7:0] converter_control_one_r;
  reg [7:0] ext_irq_ctrl_r;
  reg wr_pend_r;
  reg [5:0] wr_addr_r;
  reg [7:0] wr_data_r;
  reg [7:0] rdata_nxt;
  reg [7:0] p3_analog_nxt;
  wire rst_n;
  wire analog_input_disable;
  wire irq0_pin_select;
  wire [2:0] chsel;
  wire irq0_pulse;
  wire p11_pulse;
  wire p20_pulse;
  wire [7:0] p3_wmask;
  wire [7:0] p0_oe_nxt;
  wire [4:0] p1_oe_nxt;
  wire [4:0] p1_rd_mix;
  wire [2:0] p2_keep;
  wire [2:0] p2_oe_nxt;
  wire [7:0] p3_oe_nxt;
  wire [7:0] p3_rd_mix;
  genvar gi;

  // ============================================================
  // reset release
  fppio_rst_sync u_rst (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .rst_n_o(rst_n)
  );

  assign analog_input_disable = converter_control_one_r[`FPPIO_CONV_AIN_DIS_BIT];
  assign chsel = converter_control_one_r[`FPPIO_CONV_CHSEL_MSB:`FPPIO_CONV_CHSEL_LSB];
  assign irq0_pin_select = ext_irq_ctrl_r[`FPPIO_IRQ0_SEL_BIT];

  // one-hot of the chosen channel, used for analog and write masks
  function [7:0] fppio_onehot;
    input [2:0] idx;
    begin
      fppio_onehot = 8'h01 << idx;
    end
  endfunction

  // ============================================================
  // analog pin selection
  always @* begin
    // R18: analog selection
    if (!analog_input_disable) begin
      p3_analog_nxt = fppio_onehot(chsel);
    end else begin
      p3_analog_nxt = 8'h00;
    end
  end

  // R20: analog pins unwritable
  assign p3_wmask = ~p3_analog_nxt;

  // ============================================================
  // read path: pins sampled in the request cycle
  always @* begin
    rdata_nxt = 8'h00;
    // unmapped addresses read zero; writes to them are dropped
    case (bus_addr_i)
      // R6: latch contents
      `FPPIO_ADDR_P0_LATCH: rdata_nxt = port0_output_latch_r;
      // R22: input bits read pins
      `FPPIO_ADDR_P1_LATCH: rdata_nxt = {3'h0, p1_rd_mix};
      // R15: upper bits read zero
      `FPPIO_ADDR_P2_LATCH: rdata_nxt = {5'h00, port2_output_latch_r};
      // R20: analog pins return latch
      `FPPIO_ADDR_P3_LATCH: rdata_nxt = p3_rd_mix;
      `FPPIO_ADDR_P1_DIR: rdata_nxt = {3'h0, port1_direction_r};
      `FPPIO_ADDR_P3_DIR: rdata_nxt = port3_direction_r;
      `FPPIO_ADDR_P0_DRIVE: rdata_nxt = port0_drive_select_r;
      // R6: pin-state register
      `FPPIO_ADDR_P0_PINS: rdata_nxt = p0_pin_i;
      // R15: pin-state low bits only
      `FPPIO_ADDR_P2_PINS: rdata_nxt = {5'h00, p2_pin_i};
      `FPPIO_ADDR_CONV_CTRL1: rdata_nxt = converter_control_one_r;
      `FPPIO_ADDR_EXT_IRQ_CTRL: rdata_nxt = ext_irq_ctrl_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // ============================================================
  // bus timing
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata_o <= 8'h00;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 6'h00;
      wr_data_r <= 8'h00;
    end else begin
      // R2: sample in first state
      if (bus_rd_i) begin
        bus_rdata_o <= rdata_nxt;
      end
      // write held for the second state
      // a read in the very next cycle still sees the old value
      wr_pend_r <= bus_wr_i;
      if (bus_wr_i) begin
        wr_addr_r <= bus_addr_i;
        wr_data_r <= bus_wdata_i;
      end
    end
  end

  // ============================================================
  // register file
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      // R4: port0 reset values
      port0_output_latch_r <= `FPPIO_RST_P0_LATCH;
      port0_drive_select_r <= `FPPIO_RST_P0_DRIVE;
      // R8: port1 reset values
      port1_output_latch_r <= `FPPIO_RST_P1_LATCH;
      port1_direction_r <= `FPPIO_RST_P1_DIR;
      // R12: port2 latch ones
      port2_output_latch_r <= `FPPIO_RST_P2_LATCH;
      // R17: port3 digital inputs
      port3_output_latch_r <= `FPPIO_RST_P3_LATCH;
      port3_direction_r <= `FPPIO_RST_P3_DIR;
      converter_control_one_r <= `FPPIO_RST_CONV_CTRL1;
      // R11: port1 bit0 general input
      ext_irq_ctrl_r <= `FPPIO_RST_EXT_IRQ_CTRL;
    end else if (wr_pend_r) begin
      // R3: update in second state
      case (wr_addr_r)
        `FPPIO_ADDR_P0_LATCH: port0_output_latch_r <= wr_data_r;
        `FPPIO_ADDR_P1_LATCH: port1_output_latch_r <= wr_data_r[4:0];
        `FPPIO_ADDR_P2_LATCH: port2_output_latch_r <= wr_data_r[2:0];
        // R20: analog bits keep latch
        `FPPIO_ADDR_P3_LATCH: port3_output_latch_r <= (wr_data_r & p3_wmask)
          | (port3_output_latch_r & ~p3_wmask);
        `FPPIO_ADDR_P1_DIR: port1_direction_r <= wr_data_r[4:0];
        `FPPIO_ADDR_P3_DIR: port3_direction_r <= wr_data_r;
        `FPPIO_ADDR_P0_DRIVE: port0_drive_select_r <= wr_data_r;
        `FPPIO_ADDR_CONV_CTRL1: converter_control_one_r <= wr_data_r;
        `FPPIO_ADDR_EXT_IRQ_CTRL: ext_irq_ctrl_r <= wr_data_r;
        // read-only and unmapped addresses fall through
        default: port0_output_latch_r <= port0_output_latch_r;
      endcase
    end
  end

  // ============================================================
  // interrupt edge feeds; pins still seen while driven
  // a pin turned output can raise a pseudo edge; mask it upstream
  // R23: irq0 only when selected
  fppio_edge_det #(.MODE(`FPPIO_EDGE_FALL)) u_irq0 (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .level_i(p1_pin_i[0]),
    .enable_i(irq0_pin_select),
    .pulse_o(irq0_pulse)
  );

  // R10: both edges, even as output
  fppio_edge_det #(.MODE(`FPPIO_EDGE_BOTH)) u_p11 (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .level_i(p1_pin_i[1]),
    .enable_i(1'b1),
    .pulse_o(p11_pulse)
  );

  // R14: falling edge, even as output
  fppio_edge_det #(.MODE(`FPPIO_EDGE_FALL)) u_p20 (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .level_i(p2_pin_i[0]),
    .enable_i(1'b1),
    .pulse_o(p20_pulse)
  );

  // ============================================================
  // port0 drive enables, per bit
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_p0_oe
      // R5: low always pulls, high drives only when push-pull
      assign p0_oe_nxt[gi] = ~port0_output_latch_r[gi] | port0_drive_select_r[gi];
    end
  endgenerate

  // ============================================================
  // port1 direction and read-back, per bit
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_p1_bit
      // R8: direction one drives the pin
      assign p1_oe_nxt[gi] = port1_direction_r[gi];
      // R22: input-mode bits read the pin, so rmw may copy it
      assign p1_rd_mix[gi] = port1_direction_r[gi] ? port1_output_latch_r[gi] : p1_pin_i[gi];
    end
  endgenerate

  // ============================================================
  // port2 open drain, masked by stop and oscillator
  // R16: stop floats bit0
  // R13: oscillator owns bits 1 and 2
  assign p2_keep = {{2{~dual_clock_i}}, ~stop_mode_i};
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_p2_oe
      // latch one releases the pin so it can be an input
      assign p2_oe_nxt[gi] = ~port2_output_latch_r[gi] & p2_keep[gi];
    end
  endgenerate

  // ============================================================
  // port3 direction, analog override and read-back
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_p3_bit
      // R19: direction one drives, analog wins
      assign p3_oe_nxt[gi] = port3_direction_r[gi] & ~p3_analog_nxt[gi];
      // R20: analog pins read the latch
      assign p3_rd_mix[gi] = (port3_direction_r[gi] | p3_analog_nxt[gi])
        ? port3_output_latch_r[gi] : p3_pin_i[gi];
    end
  endgenerate

  // ============================================================
  // pin drivers, one cycle behind the latches
  // one cycle of lag traded for flop-driven pins
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      p0_out_o <= `FPPIO_RST_P0_LATCH;
      p0_oe_o <= 8'h00;
      p1_out_o <= `FPPIO_RST_P1_LATCH;
      p1_oe_o <= 5'h00;
      p2_out_o <= `FPPIO_RST_P2_LATCH;
      p2_oe_o <= 3'h0;
      osc_pins_taken_o <= 1'b0;
      p3_out_o <= `FPPIO_RST_P3_LATCH;
      p3_oe_o <= 8'h00;
      p3_analog_o <= 8'h00;
      converter_channel_select_o <= 3'h0;
      irq0_edge_o <= 1'b0;
      irq_p11_edge_o <= 1'b0;
      irq_p20_edge_o <= 1'b0;
    end else begin
      // R1: outputs from latches
      p0_out_o <= port0_output_latch_r;
      // R5: low always pulls, high drives only when push-pull
      p0_oe_o <= p0_oe_nxt;
      p1_out_o <= port1_output_latch_r;
      p1_oe_o <= p1_oe_nxt;
      // latch one releases the pin so it can be an input
      p2_out_o <= port2_output_latch_r;
      // R16: stop floats bit0
      // R13: oscillator owns bits 1 and 2
      p2_oe_o <= p2_oe_nxt;
      osc_pins_taken_o <= dual_clock_i;
      // R19: direction one drives latch
      p3_out_o <= port3_output_latch_r;
      p3_oe_o <= p3_oe_nxt;
      p3_analog_o <= p3_analog_nxt;
      converter_channel_select_o <= chsel;
      irq0_edge_o <= irq0_pulse;
      irq_p11_edge_o <= p11_pulse;
      irq_p20_edge_o <= p20_pulse;
    end
  end
endmodule // fppio_top

/* File: tb/fppio_chk_sva.sv */
`timescale 1ns/10ps
module fppio_chk (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [5:0] bus_addr_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic bus_rd_i,
  input wire logic bus_wr_i,
  input wire logic [7:0] bus_rdata_o,
  input wire logic stop_mode_i,
  input wire logic dual_clock_i,
  input wire logic [7:0] p0_pin_i,
  input wire logic [7:0] p0_out_o,
  input wire logic [7:0] p0_oe_o,
  input wire logic [4:0] p1_pin_i,
  input wire logic [2:0] p2_pin_i,
  input wire logic [2:0] p2_oe_o,
  input wire logic [7:0] p3_oe_o,
  input wire logic [7:0] p3_analog_o,
  input wire logic irq_p11_edge_o,
  input wire logic irq_p20_edge_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ============================================================
  // register path
  AST_P0_WR: assert property (bus_wr_i && bus_addr_i == 6'h00 |-> ##3 p0_out_o == $past(bus_wdata_i, 3))
    else $error("port0 drive differs from write");
  AST_P0_OE: assert property (bus_wr_i && bus_addr_i == 6'h0B |->
    ##3 (p0_oe_o & $past(bus_wdata_i, 3)) == $past(bus_wdata_i, 3))
    else $error("push-pull bit not driven");
  AST_P0_PINS: assert property (bus_rd_i && bus_addr_i == 6'h0C |=> bus_rdata_o == $past(p0_pin_i))
    else $error("port0 pin read wrong");
  AST_RD_HOLD: assert property (!bus_rd_i |=> $stable(bus_rdata_o))
    else $error("read data moved without read");
  AST_P2_UPPER: assert property (bus_rd_i && (bus_addr_i == 6'h02 || bus_addr_i == 6'h0D) |=>
    bus_rdata_o[7:3] == 5'h00)
    else $error("port2 upper bits not zero");
  // ============================================================
  // pin control
  AST_P2_STOP: assert property (stop_mode_i |=> !p2_oe_o[0])
    else $error("port2 bit0 driven in stop");
  AST_P2_DUAL: assert property (dual_clock_i |=> p2_oe_o[2:1] == 2'h0)
    else $error("oscillator pins driven");
  AST_P3_ANALOG: assert property ((p3_oe_o & p3_analog_o) == 8'h00)
    else $error("analog pin driven");
  AST_P3_SEL: assert property (bus_wr_i && bus_addr_i == 6'h0E && !bus_wdata_i[4] |->
    ##3 p3_analog_o == (8'h01 << $past(bus_wdata_i[2:0], 3)))
    else $error("analog pin not the selected channel");
  AST_P11_EDGE: assert property ($changed(p1_pin_i[1]) |-> ##[1:2] irq_p11_edge_o)
    else $error("port1 bit1 edge lost");
  AST_P20_FALL: assert property ($fell(p2_pin_i[0]) |-> ##[1:2] irq_p20_edge_o)
    else $error("port2 bit0 fall lost");
  COV_P0_WR: cover property (bus_wr_i && bus_addr_i == 6'h00);
  COV_P20: cover property (irq_p20_edge_o);
  COV_ANALOG: cover property (|p3_analog_o);
endmodule // fppio_chk

bind fppio_top fppio_chk chk_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .bus_addr_i(bus_addr_i),
  .bus_wdata_i(bus_wdata_i), .bus_rd_i(bus_rd_i), .bus_wr_i(bus_wr_i), .bus_rdata_o(bus_rdata_o),
  .stop_mode_i(stop_mode_i), .dual_clock_i(dual_clock_i), .p0_pin_i(p0_pin_i), .p0_out_o(p0_out_o),
  .p0_oe_o(p0_oe_o), .p1_pin_i(p1_pin_i), .p2_pin_i(p2_pin_i), .p2_oe_o(p2_oe_o), .p3_oe_o(p3_oe_o),
  .p3_analog_o(p3_analog_o), .irq_p11_edge_o(irq_p11_edge_o), .irq_p20_edge_o(irq_p20_edge_o));

/* File: tb/fppio_board.sv */
`timescale 1ns/10ps
module fppio_board (
  input wire logic [23:0] out_i,
  input wire logic [23:0] oe_i,
  input wire logic [23:0] ext_i,
  output wire logic [23:0] pin_o
);
  // ============================================================
  // pin resolution
  // driven bits win
  assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule // fppio_board

/* File: tb/tb.sv */
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [7:0] wd = 8'h00;
  logic rdr = 1'b0;
  logic wrr = 1'b0;
  logic stop = 1'b0;
  logic dual = 1'b0;
  logic [23:0] ext = {8'h1C, 3'h7, 5'h14, 8'hF0};
  logic [23:0] pin;
  logic [7:0] rdata, p0o, p0e, p3o, p3e, p3a;
  logic [4:0] p1o, p1e;
  logic [2:0] p2o, p2e, csel;
  logic osc, i0, i11, i20;
  logic [2:0] seen = 3'h0;
  logic clr = 1'b0;
  int miscompares = 0;
  int comparisons = 0;
  int cyc = 0;
  always #2.5 clk = ~clk;
  fppio_top dut_u (.sys_clk_i(clk), .rst_n_i(rst_n), .bus_addr_i(addr), .bus_wdata_i(wd), .bus_rd_i(rdr),
    .bus_wr_i(wrr), .bus_rdata_o(rdata), .stop_mode_i(stop), .dual_clock_i(dual), .p0_pin_i(pin[7:0]),
    .p0_out_o(p0o), .p0_oe_o(p0e), .p1_pin_i(pin[12:8]), .p1_out_o(p1o), .p1_oe_o(p1e), .p2_pin_i(pin[15:13]),
    .p2_out_o(p2o), .p2_oe_o(p2e), .osc_pins_taken_o(osc), .p3_pin_i(pin[23:16]), .p3_out_o(p3o),
    .p3_oe_o(p3e), .p3_analog_o(p3a), .converter_channel_select_o(csel), .irq0_edge_o(i0),
    .irq_p11_edge_o(i11), .irq_p20_edge_o(i20));
  fppio_board board_u (.out_i({p3o, p2o, p1o, p0o}), .oe_i({p3e, p2e, p1e, p0e}), .ext_i(ext), .pin_o(pin));
  // ============================================================
  // helpers
  always @(posedge clk) begin
    seen <= clr ? 3'h0 : (seen | {i20, i11, i0});
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      print_verdict();
    end
  end
  task print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task ck(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wd = d;
    wrr = 1'b1;
    @(negedge clk);
    wrr = 1'b0;
    @(negedge clk);
  endtask
  task rd(input logic [5:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    rdr = 1'b1;
    @(negedge clk);
    rdr = 1'b0;
    ck(rdata, e);
  endtask
  // ============================================================
  // tests
  initial begin
    w(10);
    rst_n = 1'b1;
    w(3);
    rd(6'h00, 8'hFF);
    rd(6'h0B, 8'h00);
    rd(6'h09, 8'h00);
    rd(6'h01, 8'h14);
    rd(6'h02, 8'h07);
    rd(6'h0A, 8'h00);
    rd(6'h03, 8'h1C);
    rd(6'h0E, 8'h10);
    rd(6'h04, 8'h00);
    ck(p3e, 8'h00);
    ck(p0e, 8'h00);
    $display("test reset done");
    wr(6'h00, 8'h55);
    w(1);
    ck(p0e, 8'hAA);
    ck(p0o, 8'h55);
    rd(6'h0C, 8'h50);
    rd(6'h00, 8'h55);
    wr(6'h0B, 8'h0F);
    wr(6'h0C, 8'h00);
    wr(6'h04, 8'hFF);
    rd(6'h0C, 8'h55);
    rd(6'h0B, 8'h0F);
    rd(6'h04, 8'h00);
    $display("test port0 done");
    wr(6'h01, 8'h1F);
    wr(6'h09, 8'h02);
    w(1);
    ck({3'h0, p1e}, 8'h02);
    rd(6'h01, 8'h16);
    clr = 1'b1;
    w(1);
    clr = 1'b0;
    wr(6'h01, 8'h1D);
    w(4);
    ck({5'h00, seen}, 8'h02);
    ck({3'h0, p1o}, 8'h1D);
    ext[8] = 1'b1;
    w(3);
    ext[8] = 1'b0;
    w(3);
    ck({7'h00, seen[0]}, 8'h00);
    wr(6'h37, 8'h40);
    rd(6'h37, 8'h40);
    ext[8] = 1'b1;
    w(3);
    ext[8] = 1'b0;
    w(3);
    ck({7'h00, seen[0]}, 8'h01);
    $display("test port1 done");
    clr = 1'b1;
    w(1);
    clr = 1'b0;
    wr(6'h02, 8'h00);
    w(4);
    ck({5'h00, p2e}, 8'h07);
    ck({5'h00, seen[2], 2'h0}, 8'h04);
    rd(6'h0D, 8'h00);
    dual = 1'b1;
    w(2);
    ck({osc, 4'h0, p2e}, 8'h81);
    rd(6'h0D, 8'h06);
    stop = 1'b1;
    w(2);
    ck({5'h00, p2e}, 8'h00);
    rd(6'h0D, 8'h07);
    rd(6'h02, 8'h00);
    dual = 1'b0;
    stop = 1'b0;
    $display("test port2 done");
    wr(6'h03, 8'hA5);
    wr(6'h0A, 8'h0F);
    rd(6'h03, 8'h15);
    wr(6'h0E, 8'h05);
    w(1);
    ck(p3a, 8'h20);
    ck({5'h00, csel}, 8'h05);
    ck(p3e, 8'h0F);
    rd(6'h03, 8'h35);
    rd(6'h0E, 8'h05);
    wr(6'h03, 8'h00);
    rd(6'h03, 8'h30);
    ck(p3o, 8'h20);
    $display("test port3 done");
    print_verdict();
  end
endmodule // tb
